// ---- rtl/dmarc_pkg.sv ----
// dmarc_pkg: register offsets, field positions and encodings for the dma register/command logic.
// assumes an apb slave with 32-bit data; each 8-bit register sits in the low byte of an aligned word.
package dmarc_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_CHECKOUT_PTR  = 8'h00;
	localparam logic [7:0] IDX_CHECKOUT_DATA = 8'h01;
	localparam logic [7:0] IDX_CH1_ADDR      = 8'h02;
	localparam logic [7:0] IDX_CH1_COUNT     = 8'h03;
	localparam logic [7:0] IDX_CH2_ADDR      = 8'h04;
	localparam logic [7:0] IDX_CH2_COUNT     = 8'h05;
	localparam logic [7:0] IDX_CH3_ADDR      = 8'h06;
	localparam logic [7:0] IDX_CH3_COUNT     = 8'h07;
	localparam logic [7:0] IDX_SINGLE_MASK   = 8'h0A;
	localparam logic [7:0] IDX_XFER_CONFIG   = 8'h0B;
	localparam logic [7:0] IDX_BP_CLEAR      = 8'h0C;
	localparam logic [7:0] IDX_REINIT        = 8'h0D;
	localparam logic [7:0] IDX_UNMASK_ALL    = 8'h0E;
	localparam logic [7:0] IDX_MASK_ALL      = 8'h0F;
	localparam logic [7:0] IDX_CH2_PAGE      = 8'h81;
	localparam logic [7:0] IDX_CH3_PAGE      = 8'h82;
	localparam logic [7:0] IDX_CH1_PAGE      = 8'h83;
	// checkout pointer selections
	localparam logic [7:0] CHK_MASK          = 8'h03;
	localparam logic [7:0] CHK_MODE_CH1      = 8'h08;
	localparam logic [7:0] CHK_MODE_CH2      = 8'h09;
	localparam logic [7:0] CHK_MODE_CH3      = 8'h0A;
	// field positions
	localparam int XFER_MODE_HI = 7;
	localparam int XFER_MODE_LO = 6;
	localparam int ADDR_STEP_BIT = 5;
	localparam int DIR_HI = 3;
	localparam int DIR_LO = 2;
	localparam int SEL_HI = 1;
	localparam int SEL_LO = 0;
	localparam int SMASK_BIT = 2;
	localparam int AMASK_HI = 3;
	localparam int AMASK_LO = 1;
	// reset values
	localparam logic [7:0]  MODE_RESET  = 8'h00;
	localparam logic [2:0]  MASK_RESET  = 3'h7;
	localparam logic [15:0] WORD_RESET  = 16'h0000;
	localparam logic [3:0]  PAGE_RESET  = 4'h0;
	localparam logic [7:0]  PTR_RESET   = 8'h00;
	typedef enum logic [1:0] {
		DMARC_DIR_VERIFY = 2'b00,
		DMARC_DIR_WRITE  = 2'b01,
		DMARC_DIR_READ   = 2'b10,
		DMARC_DIR_BAD    = 2'b11
	} dmarc_dir_t;
	typedef enum logic [1:0] {
		DMARC_XM_DEMAND = 2'b00,
		DMARC_XM_SINGLE = 2'b01,
		DMARC_XM_BLOCK  = 2'b10,
		DMARC_XM_BAD    = 2'b11
	} dmarc_xmode_t;
endpackage

// ---- rtl/dmarc_word_reg.sv ----
// dmarc_word_reg: one 16-bit register loaded and read a byte at a time.
// assumes the caller supplies the shared byte pointer and a one-cycle write strobe.
`timescale 1ns/10ps
`default_nettype none
module dmarc_word_reg
	import dmarc_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        init,
	input  wire logic        wr,
	input  wire logic        high_sel,
	input  wire logic [7:0]  wdata,
	output logic      [15:0] value,
	output logic      [7:0]  rbyte
);
	// pointer picks which half is touched
	assign rbyte = high_sel ? value[15:8] : value[7:0];

	// storage; init comes from the global reinit command
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			value <= WORD_RESET;
		else if (init)
			value <= WORD_RESET;
		else if (wr && high_sel)
			value[15:8] <= wdata;
		else if (wr)
			value[7:0] <= wdata;
	end
endmodule
`default_nettype wire

// ---- rtl/dmarc_top.sv ----
// dmarc_top: programming-side register and command logic of a three-channel dma controller.
// assumes an apb master on core_clk; the transfer engine consumes the mode fields, masks and addresses.
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - mode bits 3-2 give transfer direction
// - mode bits 1-0 pick target channel
// - byte pointer selects low or high byte
// - pointer toggles after each byte access to a word register
// - pointer cleared by reset, reinit, clear command
// - pointer clear ignores write data
// - reinit restores defaults, masks all channels
// - unmask command clears all mask bits
// - mask-all loads masks from bits 3-1
// - checkout pointer 03 reads mask bits
// - mode bits 7-6 give transfer mode
// - mode bit 5 picks address step
// - single-mask write sets/clears one channel
// - transfer address is page above address register
module dmarc_top
	import dmarc_pkg::*;
#(
	parameter int NUM_CH = 3
)
(
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [NUM_CH-1:0]     dreq_in,
	output logic      [NUM_CH-1:0]     req_granted,
	output logic      [NUM_CH-1:0]     chan_mask,
	output dmarc_dir_t [NUM_CH-1:0]    chan_dir,
	output dmarc_xmode_t [NUM_CH-1:0]  chan_xmode,
	output logic      [NUM_CH-1:0]     chan_addr_inc,
	output logic      [NUM_CH*20-1:0]  chan_xfer_addr,
	output logic                       byte_ptr
);
	import dmarc_pkg::*;

	if (NUM_CH != 3) begin : g_bad_ch
		$error("dmarc_top supports exactly three channels");
	end

	// channel select code 01/10/11 maps to index 0/1/2; 00 selects none
	function automatic logic [NUM_CH-1:0] sel_onehot(input logic [1:0] code);
		logic [NUM_CH-1:0] r;
		r = '0;
		unique case (code)
			2'b01: r = 3'b001;
			2'b10: r = 3'b010;
			2'b11: r = 3'b100;
			2'b00: r = '0;
		endcase
		return r;
	endfunction

	// apb decode; registers are byte-wide in the low lane of aligned words
	wire logic        acc       = psel && penable;
	wire logic        wr_acc    = acc && pwrite;
	wire logic        rd_acc    = acc && !pwrite;
	wire logic        aligned   = (paddr[1:0] == 2'b00);
	wire logic [7:0]  idx       = paddr[9:2];
	wire logic        hi_zero   = (paddr[11:10] == 2'b00);
	wire logic [7:0]  wbyte     = pwdata[7:0];

	function automatic logic hit(input logic [7:0] i, input logic [7:0] want, input logic ok);
		return ok && (i == want);
	endfunction

	wire logic ok_addr = aligned && hi_zero;
	wire logic is_ptr   = hit(idx, IDX_CHECKOUT_PTR, ok_addr);
	wire logic is_data  = hit(idx, IDX_CHECKOUT_DATA, ok_addr);
	wire logic is_smask = hit(idx, IDX_SINGLE_MASK, ok_addr);
	wire logic is_cfg   = hit(idx, IDX_XFER_CONFIG, ok_addr);
	wire logic is_bpclr = hit(idx, IDX_BP_CLEAR, ok_addr);
	wire logic is_reini = hit(idx, IDX_REINIT, ok_addr);
	wire logic is_unm   = hit(idx, IDX_UNMASK_ALL, ok_addr);
	wire logic is_mall  = hit(idx, IDX_MASK_ALL, ok_addr);
	wire logic is_word  = ok_addr && (idx >= IDX_CH1_ADDR) && (idx <= IDX_CH3_COUNT);
	wire logic is_page  = ok_addr && (idx >= IDX_CH2_PAGE) && (idx <= IDX_CH1_PAGE);
	wire logic is_wo    = is_smask | is_cfg | is_bpclr | is_reini | is_unm | is_mall | is_page;
	wire logic is_rw    = is_ptr | is_data | is_word;
	// reads and writes to holes and reads of write-only ports answer with an error
	wire logic mapped   = pwrite ? (is_wo | is_rw) : is_rw;

	// command and write strobes; reinit, pointer clear and unmask ignore data, the others load it
	wire logic reinit_cmd = wr_acc && is_reini;
	wire logic bpclr_cmd  = wr_acc && is_bpclr;
	wire logic unmask_cmd = wr_acc && is_unm;
	wire logic mall_wr    = wr_acc && is_mall;
	wire logic smask_wr   = wr_acc && is_smask;
	wire logic cfg_wr     = wr_acc && is_cfg;
	wire logic word_acc   = acc && is_word;

	// channel picked by bits 1-0, shared by mode and single-mask writes
	wire logic [NUM_CH-1:0] cfg_sel = sel_onehot(wbyte[SEL_HI:SEL_LO]);

	// control state
	logic [7:0]        chk_ptr;
	logic [7:0]        mode_reg [NUM_CH];
	logic [3:0]        page_reg [NUM_CH];
	logic [NUM_CH-1:0] next_mask;

	// mask update; reinit wins so all channels end masked
	always_comb
	begin
		next_mask = chan_mask;
		if (mall_wr)
			next_mask = wbyte[AMASK_HI:AMASK_LO];
		if (smask_wr)
		begin
			for (int c = 0; c < NUM_CH; c++)
				if (cfg_sel[c])
					next_mask[c] = wbyte[SMASK_BIT];
		end
		if (unmask_cmd)
			next_mask = '0;
		if (reinit_cmd)
			next_mask = MASK_RESET;
	end

	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			chan_mask <= MASK_RESET;
		else
			chan_mask <= next_mask;
	end

	// byte pointer; clears outrank the toggle so a clear is never lost
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			byte_ptr <= 1'b0;
		else if (reinit_cmd || bpclr_cmd)
			byte_ptr <= 1'b0;
		else if (word_acc)
			byte_ptr <= ~byte_ptr;
	end

	// checkout pointer and per-channel mode and page registers
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			chk_ptr <= PTR_RESET;
		else if (reinit_cmd)
			chk_ptr <= PTR_RESET;
		else if (wr_acc && is_ptr)
			chk_ptr <= wbyte;
	end

	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		// page order on the bus is ch2, ch3, ch1
		localparam logic [7:0] PAGE_IDX = (c == 0) ? IDX_CH1_PAGE : (c == 1) ? IDX_CH2_PAGE : IDX_CH3_PAGE;
		always_ff @(posedge core_clk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				mode_reg[c] <= MODE_RESET;
				page_reg[c] <= PAGE_RESET;
			end
			else if (reinit_cmd)
			begin
				mode_reg[c] <= MODE_RESET;
				page_reg[c] <= PAGE_RESET;
			end
			else
			begin
				if (cfg_wr && cfg_sel[c])
					mode_reg[c] <= wbyte;
				if (wr_acc && ok_addr && idx == PAGE_IDX)
					page_reg[c] <= wbyte[3:0];
			end
		end
		// mode fields handed to the transfer engine
		assign chan_dir[c]      = dmarc_dir_t'(mode_reg[c][DIR_HI:DIR_LO]);
		assign chan_xmode[c]    = dmarc_xmode_t'(mode_reg[c][XFER_MODE_HI:XFER_MODE_LO]);
		assign chan_addr_inc[c] = mode_reg[c][ADDR_STEP_BIT];
		// masked channels see no grant until unmasked
		assign req_granted[c]   = dreq_in[c] && !chan_mask[c];
	end

	// word registers: address then count per channel, indices 02..07
	logic [15:0] word_val [2*NUM_CH];
	logic [7:0]  word_byte [2*NUM_CH];
	for (genvar w = 0; w < 2*NUM_CH; w++) begin : g_word
		dmarc_word_reg u_word (
			.core_clk (core_clk),
			.sys_rst  (sys_rst),
			.init     (reinit_cmd),
			.wr       (wr_acc && is_word && idx == IDX_CH1_ADDR + 8'(w)),
			.high_sel (byte_ptr),
			.wdata    (wbyte),
			.value    (word_val[w]),
			.rbyte    (word_byte[w])
		);
	end

	// 20-bit transfer address: page on top of current address
	for (genvar c = 0; c < NUM_CH; c++) begin : g_addr
		assign chan_xfer_addr[c*20 +: 20] = {page_reg[c], word_val[2*c]};
	end

	// checkout data selection
	logic [7:0] chk_data;
	always_comb
	begin
		unique case (chk_ptr)
			CHK_MASK:     chk_data = {4'h0, chan_mask, 1'b0};
			CHK_MODE_CH1: chk_data = mode_reg[0];
			CHK_MODE_CH2: chk_data = mode_reg[1];
			CHK_MODE_CH3: chk_data = mode_reg[2];
			default:      chk_data = 8'h00;
		endcase
	end

	wire logic [2:0] word_ix = 3'(idx - IDX_CH1_ADDR);
	wire logic [7:0] rd_byte = is_ptr  ? chk_ptr :
	                           is_data ? chk_data :
	                           is_word ? word_byte[word_ix] : 8'h00;

	// zero-wait slave; read data registered at the edge that ends the setup phase
	assign pready  = 1'b1;
	assign pslverr = acc && !mapped;
	always_ff @(posedge core_clk or posedge sys_rst)
	begin
		if (sys_rst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h00_0000, rd_byte};
	end
endmodule
`default_nettype wire

// ---- test/dmarc_checker.sv ----
// dmarc_checker: port-level checks of the dma register and command logic.
// assumes it is bound into dmarc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module dmarc_checker
	import dmarc_pkg::*;
#(
	parameter int NUM_CH = 3
)
(
	input wire logic                            core_clk,
	input wire logic                            sys_rst,
	input wire logic                            psel,
	input wire logic                            penable,
	input wire logic                            pwrite,
	input wire logic [11:0]                     paddr,
	input wire logic [31:0]                     pwdata,
	input wire logic                            pready,
	input wire logic                            pslverr,
	input wire logic [NUM_CH-1:0]               dreq_in,
	input wire logic [NUM_CH-1:0]               req_granted,
	input wire logic [NUM_CH-1:0]               chan_mask,
	input wire dmarc_pkg::dmarc_dir_t [NUM_CH-1:0] chan_dir,
	input wire logic                            byte_ptr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// only accepted accesses count; a refused one must leave state alone
	wire logic acc_ok  = psel & penable & pready & ~pslverr;
	wire logic wr_ok   = acc_ok & pwrite;
	wire logic mode_wr = wr_ok & (paddr == 12'h02C);
	wire logic word_ac = acc_ok & (paddr >= 12'h008) & (paddr <= 12'h01C);
	property p_dir; mode_wr && pwdata[1:0] == 2'b01 |=> chan_dir[0] == $past(pwdata[3:2]); endproperty
	a_dir: assert property (p_dir) else $error("channel 1 direction not loaded");
	property p_sel; mode_wr && pwdata[1:0] == 2'b11 |=> chan_dir[0] == $past(chan_dir[0]); endproperty
	a_sel: assert property (p_sel) else $error("wrong channel mode loaded");
	property p_tog; word_ac |=> byte_ptr != $past(byte_ptr); endproperty
	a_tog: assert property (p_tog) else $error("byte pointer did not toggle");
	property p_bpclr; wr_ok && paddr == 12'h030 |=> !byte_ptr; endproperty
	a_bpclr: assert property (p_bpclr) else $error("byte pointer not cleared");
	property p_reinit; wr_ok && paddr == 12'h034 |=> chan_mask == 3'h7 && !byte_ptr; endproperty
	a_reinit: assert property (p_reinit) else $error("reinit left state");
	property p_unmask; wr_ok && paddr == 12'h038 |=> chan_mask == 3'h0; endproperty
	a_unmask: assert property (p_unmask) else $error("unmask left a mask set");
	property p_all; wr_ok && paddr == 12'h03C |=> chan_mask == $past(pwdata[3:1]); endproperty
	a_all: assert property (p_all) else $error("mask-all load wrong");
	property p_single; wr_ok && paddr == 12'h028 && pwdata[1:0] == 2'b10 |=> chan_mask[1] == $past(pwdata[2]); endproperty
	a_single: assert property (p_single) else $error("single mask wrong");
	property p_grant; req_granted == (dreq_in & ~chan_mask); endproperty
	a_grant: assert property (p_grant) else $error("masked request granted");
	c_mode: cover property (mode_wr);
	c_word: cover property (word_ac ##[1:4] word_ac);
	c_grant: cover property (|req_granted);
endmodule
bind dmarc_top dmarc_checker #(.NUM_CH(NUM_CH)) dmarc_checker_i (.core_clk, .sys_rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .dreq_in, .req_granted, .chan_mask, .chan_dir, .byte_ptr);
`default_nettype wire

// ---- test/test_dma_register_command_logic.sv ----
// test_dma_register_command_logic: self-checking apb bench for dmarc_top.
// assumes dmarc_pkg, dmarc_top and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_dma_register_command_logic;
	import dmarc_pkg::*;
	logic               core_clk = 1'b0;
	logic               sys_rst  = 1'b1;
	logic               psel     = 1'b0;
	logic               penable  = 1'b0;
	logic               pwrite   = 1'b0;
	logic [11:0]        paddr    = 12'h000;
	logic [31:0]        pwdata   = 32'h0;
	logic [2:0]         dreq_in  = 3'h0;
	wire  [31:0]        prdata;
	wire                pready;
	wire                pslverr;
	wire  [2:0]         req_granted;
	wire  [2:0]         chan_mask;
	dmarc_dir_t [2:0]   chan_dir;
	dmarc_xmode_t [2:0] chan_xmode;
	wire  [2:0]         chan_addr_inc;
	wire  [59:0]        chan_xfer_addr;
	wire                byte_ptr;
	logic [31:0]        rdv;
	logic               errv;
	logic [7:0]         lo;
	logic [7:0]         hi;
	logic [7:0]         m;
	integer             seed = 31726;
	int                 error_cnt = 0;
	int                 compares = 0;
	int                 i;
	int                 j;
	// 50 MHz clock
	always #10 core_clk = ~core_clk;
	dmarc_top #(.NUM_CH(3)) dmarc_top_i (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .dreq_in, .req_granted, .chan_mask, .chan_dir, .chan_xmode, .chan_addr_inc,
		.chan_xfer_addr, .byte_ptr);
	task automatic print_verdict();
		if (error_cnt == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer; checks follow at the falling edge so register updates have landed
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		dreq_in <= 3'($random(seed));
		@(negedge core_clk);
		if (n == 16)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask
	// main sequence: modes, byte pointer, commands, masks
	initial
	begin
		repeat (3) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (i = 1; i < 4; i++)
			for (j = 0; j < 3; j++)
			begin
				m = {2'((i + j) % 3), 2'($random(seed)), 2'(j), 2'(i)};
				apb(1, 12'h02C, {24'h0, m});
				chk("dir", 32'(j), 32'(chan_dir[i-1]));
				chk("xmode", 32'(m[7:6]), 32'(chan_xmode[i-1]));
				chk("step", 32'(m[5]), 32'(chan_addr_inc[i-1]));
			end
		apb(1, 12'h02C, 32'h04);
		chk("sel", 32'h2A, 32'(chan_dir));
		lo = 8'($random(seed));
		hi = 8'($random(seed));
		apb(1, 12'h008, {24'h0, lo});
		chk("ptr_set", 32'h1, 32'(byte_ptr));
		apb(1, 12'h008, {24'h0, hi});
		apb(1, 12'h20C, 32'h5);
		chk("xaddr", {12'h0, 4'h5, hi, lo}, 32'(chan_xfer_addr[19:0]));
		apb(0, 12'h008, 32'h0);
		chk("rd_lo", {24'h0, lo}, rdv);
		apb(0, 12'h008, 32'h0);
		chk("rd_hi", {24'h0, hi}, rdv);
		apb(0, 12'h01C, 32'h0);
		apb(1, 12'h030, $random(seed));
		chk("bp_cmd", 32'h0, 32'(byte_ptr));
		apb(0, 12'h01C, 32'h0);
		apb(1, 12'h038, $random(seed));
		chk("unmask", 32'h0, 32'(chan_mask));
		apb(1, 12'h034, $random(seed));
		chk("re_ptr", 32'h0, 32'(byte_ptr));
		chk("re_mask", 32'h7, 32'(chan_mask));
		chk("re_addr", 32'h0, 32'(chan_xfer_addr[19:0]));
		chk("re_mode", 32'h0, 32'(chan_dir));
		apb(1, 12'h000, 32'h03);
		// all-zero and all-one corners first, then random patterns
		for (i = 0; i < 8; i++)
		begin
			m = (i < 2) ? {8{i[0]}} : 8'($random(seed));
			apb(1, 12'h03C, {24'h0, m});
			chk("mask_all", 32'(m[3:1]), 32'(chan_mask));
			chk("grant", 32'(dreq_in & ~m[3:1]), 32'(req_granted));
			apb(0, 12'h004, 32'h0);
			chk("chk_mask", {28'h0, m[3:1], 1'b0}, rdv);
		end
		// start from ch3 masked only, so every single-mask write flips its bit
		apb(1, 12'h03C, 32'h08);
		for (i = 1; i < 4; i++)
		begin
			m = {5'h0, 1'(i[0] ^ i[1]), 2'(i)};
			apb(1, 12'h028, {24'h0, m});
			chk("single", 32'(m[2]), 32'(chan_mask[i-1]));
		end
		apb(0, 12'h004, 32'h0);
		chk("smask_rd", 32'h06, rdv);
		apb(0, 12'h0FC, 32'h0);
		chk("unmapped", 32'h1, 32'(errv));
		print_verdict();
	end
endmodule
`default_nettype wire
